// file: rtl/mps_pkg.sv
// package: constants, states and carrier structs of the module power sequencer
package mps_pkg;

  // synchroniser depth (three flops, second and third must agree)
  localparam int SYNC_STAGES = 3;

  // internal supply settle time after input power is good
  localparam int SUPPLY_SETTLE_US = 10;
  localparam int CLK_MHZ = 10;
  localparam int SUPPLY_SETTLE_CYC = (SUPPLY_SETTLE_US * CLK_MHZ < 1) ? 1 :
                                     SUPPLY_SETTLE_US * CLK_MHZ;
  // carrier rail settle time between carrier enable and reset release
  localparam int CARRIER_SETTLE_US = 100;
  localparam int CARRIER_SETTLE_CYC = (CARRIER_SETTLE_US * CLK_MHZ < 1) ? 1 :
                                      CARRIER_SETTLE_US * CLK_MHZ;
  localparam int CNT_W = 16;

  // output values after reset
  localparam logic RST_SUPPLY_EN = 1'h0;
  localparam logic RST_CARRIER_EN = 1'h0;
  localparam logic RST_STANDBY_N = 1'h0;
  localparam logic RST_RESET_OUT_N = 1'h0;

  // one-hot sequencer states
  typedef enum logic [5:0] {
    MPS_OFF      = 6'h01,
    MPS_SUPPLY   = 6'h02,
    MPS_WAIT_BTN = 6'h04,
    MPS_CARRIER  = 6'h08,
    MPS_RUN      = 6'h10,
    MPS_SOFT_OFF = 6'h20
  } mps_state_t;

  // synchronised carrier inputs, active high
  typedef struct packed {
    logic power_good;
    logic reset_request;
    logic button_pressed;
  } mps_inputs_t;

  // outputs toward the carrier and the module
  typedef struct packed {
    logic supply_enable;
    logic carrier_supply_enable;
    logic carrier_standby_n;
    logic reset_out_n;
  } mps_outputs_t;

endpackage : mps_pkg

// file: rtl/mps_sync.sv
// three-flop input synchroniser with agreement filter
`timescale 1ns/1ps
module mps_sync
  import mps_pkg::*;
#(
  parameter logic RESET_VALUE = 1'h0
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic async_in,
  output logic sync_out
);

  logic [SYNC_STAGES-1:0] stage_q;
  logic [SYNC_STAGES-1:0] stage_d;
  logic sync_q;
  logic sync_d;

  // shift chain; output changes only when the last two stages agree
  always_comb begin
    stage_d = {stage_q[SYNC_STAGES-2:0], async_in};
    sync_d = sync_q;
    if (stage_q[1] == stage_q[2]) begin
      sync_d = stage_q[2];
    end
  end

  // registers
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      stage_q <= {SYNC_STAGES{RESET_VALUE}};
      sync_q <= RESET_VALUE;
    end else begin
      stage_q <= stage_d;
      sync_q <= sync_d;
    end
  end

  assign sync_out = sync_q;

endmodule : mps_sync

// file: rtl/mps_sequencer.sv
// power-up and reset sequencer of the compute module
`timescale 1ns/1ps
// How it works
// RQ1: internal supplies turn on only while input_power_fault_n is high.
// RQ2: low input_power_fault_n means input not ready; power-up does not proceed.
// RQ3: carrier holds input_power_fault_n low until its input is stable.
// RQ4: after own supplies and button event, assert carrier enable and standby.
// RQ5: reset output releases only after carrier power is enabled.
// RQ6: carrier_supply_enable is active high, asserted once module supplies are up.
// RQ7: carrier_standby_n is active low; low marks suspend or off.
// RQ8: carrier may drop unneeded rails while standby is low.
// RQ9: reset request low from carrier forces a module reset.
// RQ10: reset output stays low through sequencing, goes high to boot.
// RQ11: power button press wakes from or shuts down to soft-off.
// RQ12: all three carrier inputs are synchronised before use.
// RQ13: input power loss returns to off, drops carrier outputs, asserts reset.
module mps_sequencer
  import mps_pkg::*;
#(
  parameter bit BUTTON_PRESENT = 1'b1,
  parameter int SUPPLY_CYCLES = SUPPLY_SETTLE_CYC,
  parameter int CARRIER_CYCLES = CARRIER_SETTLE_CYC
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic input_power_fault_n,
  input wire logic reset_request_n,
  input wire logic power_button_input_n,
  output logic supply_enable,
  output logic carrier_supply_enable,
  output logic carrier_standby_n,
  output logic reset_out_n
);

  // refuse settle counts that the settle counter cannot hold
  // the counter loads the count minus one and stops at zero
  if (SUPPLY_CYCLES < 1 || SUPPLY_CYCLES >= (1 << CNT_W) ||
      CARRIER_CYCLES < 1 || CARRIER_CYCLES >= (1 << CNT_W)) begin : g_bad_settle
    $error("settle counts out of range");
  end

  ////////////////////////////////////////////////////////////////////////////
  // input synchronisers
  // each pin passes four flops (three stages and the filter flop) before the state machine sees it
  // reset values equal the idle pin levels, so no false press follows reset
  mps_inputs_t in_s;
  logic pwr_ok_raw;
  logic rst_req_n_raw;
  logic btn_n_raw;

  mps_sync #(.RESET_VALUE(1'h0)) u_sync_pwr (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .async_in(input_power_fault_n),
    .sync_out(pwr_ok_raw)
  ); // RQ12
  mps_sync #(.RESET_VALUE(1'h1)) u_sync_rst (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .async_in(reset_request_n),
    .sync_out(rst_req_n_raw)
  ); // RQ12
  mps_sync #(.RESET_VALUE(1'h1)) u_sync_btn (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .async_in(power_button_input_n),
    .sync_out(btn_n_raw)
  ); // RQ12

  // active-high view of the inputs
  // the reset request is a level, not an asynchronous reset of the block
  always_comb begin
    in_s.power_good = pwr_ok_raw;
    in_s.reset_request = !rst_req_n_raw;
    in_s.button_pressed = !btn_n_raw;
  end

  ////////////////////////////////////////////////////////////////////////////
  // button edge detection on the synchronised level
  // a press fires once however long the button is held
  logic btn_prev_q;
  logic btn_prev_d;
  logic btn_event;

  always_comb begin
    btn_prev_d = in_s.button_pressed;
    btn_event = in_s.button_pressed && !btn_prev_q; // RQ11
  end

  // previous button level
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      btn_prev_q <= 1'h0;
    end else begin
      btn_prev_q <= btn_prev_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer state machine
  mps_state_t state_q;
  mps_state_t state_d;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  mps_outputs_t out_q;
  mps_outputs_t out_d;

  // settle counter has run out
  logic settle_done;
  assign settle_done = (cnt_q == '0);

  // next state and settle counter
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    unique case (state_q)
      // wait for good input power; button and reset request are ignored here
      MPS_OFF: begin
        if (in_s.power_good) begin // RQ1
          state_d = MPS_SUPPLY;
          cnt_d = CNT_W'(SUPPLY_CYCLES - 1);
        end
      end
      // module rails settle before the carrier is considered
      MPS_SUPPLY: begin
        if (!settle_done) begin
          cnt_d = cnt_q - 1'b1;
        end else if (BUTTON_PRESENT) begin
          state_d = MPS_WAIT_BTN;
        end else begin
          state_d = MPS_CARRIER; // RQ4
          cnt_d = CNT_W'(CARRIER_CYCLES - 1);
        end
      end
      // a press seen earlier does not count; a fresh one is needed
      MPS_WAIT_BTN: begin
        if (btn_event) begin // RQ4
          state_d = MPS_CARRIER;
          cnt_d = CNT_W'(CARRIER_CYCLES - 1);
        end
      end
      // carrier rails come up while the module reset is still held
      MPS_CARRIER: begin
        if (!settle_done) begin
          cnt_d = cnt_q - 1'b1;
        end else begin
          state_d = MPS_RUN; // RQ5
        end
      end
      // booted; a press shuts down to soft-off
      MPS_RUN: begin
        if (btn_event && BUTTON_PRESENT) begin
          state_d = MPS_SOFT_OFF; // RQ11
        end
      end
      // soft-off keeps the module rails; a press restarts the carrier phase
      MPS_SOFT_OFF: begin
        if (btn_event) begin
          state_d = MPS_CARRIER; // RQ11
          cnt_d = CNT_W'(CARRIER_CYCLES - 1);
        end
      end
      // a code that is not one-hot falls back to off
      default: begin
        state_d = MPS_OFF;
        cnt_d = '0;
      end
    endcase
    // external reset request restarts the carrier phase; it wins over a press
    if (in_s.reset_request && (state_q == MPS_RUN || state_q == MPS_CARRIER)) begin
      state_d = MPS_CARRIER; // RQ9
      cnt_d = CNT_W'(CARRIER_CYCLES - 1);
    end
    // loss of input power is checked last so it overrides everything
    if (!in_s.power_good) begin
      state_d = MPS_OFF; // RQ2 RQ13
      cnt_d = '0;
    end
  end

  // state registers
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= MPS_OFF;
      cnt_q <= '0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // output decode from the next state, so every pin leaves a flip-flop
  // standby moves with the carrier enable; no suspend-to-RAM state is kept
  always_comb begin
    out_d.supply_enable = (state_d != MPS_OFF); // RQ1
    out_d.carrier_supply_enable = (state_d == MPS_CARRIER) ||
                                  (state_d == MPS_RUN); // RQ6
    out_d.carrier_standby_n = (state_d == MPS_CARRIER) ||
                              (state_d == MPS_RUN); // RQ7
    out_d.reset_out_n = (state_d == MPS_RUN) && !in_s.reset_request; // RQ10 RQ9
  end

  // output registers; all four pins come up low, reset asserted
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      out_q.supply_enable <= RST_SUPPLY_EN;
      out_q.carrier_supply_enable <= RST_CARRIER_EN;
      out_q.carrier_standby_n <= RST_STANDBY_N;
      out_q.reset_out_n <= RST_RESET_OUT_N;
    end else begin
      out_q <= out_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // output pins
  // pins are the output registers themselves, with no logic after them
  assign supply_enable = out_q.supply_enable;
  assign carrier_supply_enable = out_q.carrier_supply_enable;
  assign carrier_standby_n = out_q.carrier_standby_n;
  assign reset_out_n = out_q.reset_out_n;

endmodule : mps_sequencer

// file: verif/mps_sequencer_sva.sv
// checker: port-level rules of the module power sequencer
`timescale 1ns/1ps
module mps_sequencer_sva #(
  parameter int SUPPLY_CYCLES = 2,
  parameter int CARRIER_CYCLES = 4
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic input_power_fault_n,
  input wire logic reset_request_n,
  input wire logic power_button_input_n,
  input wire logic supply_enable,
  input wire logic carrier_supply_enable,
  input wire logic carrier_standby_n,
  input wire logic reset_out_n
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  // power gating and ordering
  a_no_power_off: assert property (!input_power_fault_n [*8] |-> !supply_enable)
    else $error("supply enabled without input power");
  a_fault_drops_all: assert property ($fell(input_power_fault_n) |-> ##[1:8]
    (!supply_enable && !carrier_supply_enable && !carrier_standby_n && !reset_out_n))
    else $error("outputs not dropped after power loss");
  a_carrier_after_sup: assert property (carrier_supply_enable |-> supply_enable)
    else $error("carrier enabled before module supplies");
  a_standby_pairs: assert property (carrier_supply_enable == carrier_standby_n)
    else $error("standby and carrier enable disagree");
  a_reset_last: assert property ($rose(reset_out_n) |->
    carrier_supply_enable && $past(carrier_supply_enable, CARRIER_CYCLES - 1))
    else $error("reset released too early");
  a_req_holds_reset: assert property (!reset_request_n [*8] |-> !reset_out_n)
    else $error("reset released while request held");
  a_req_acts: assert property ($fell(reset_request_n) && reset_out_n |-> ##[1:8] !reset_out_n)
    else $error("reset request not obeyed");
  a_press_sleeps: assert property ($fell(power_button_input_n) && reset_out_n
    |-> ##[1:8] !carrier_supply_enable)
    else $error("button press in run did not shut down");
  // main scenarios
  c_boot: cover property ($rose(reset_out_n));
  c_soft_off: cover property ($fell(carrier_supply_enable) && supply_enable);
  c_power_loss: cover property ($fell(supply_enable));
endmodule : mps_sequencer_sva
bind mps_sequencer mps_sequencer_sva #(.SUPPLY_CYCLES(SUPPLY_CYCLES),
  .CARRIER_CYCLES(CARRIER_CYCLES)) mps_sequencer_sva_i (.clk_sys, .rst_b,
  .input_power_fault_n, .reset_request_n, .power_button_input_n, .supply_enable,
  .carrier_supply_enable, .carrier_standby_n, .reset_out_n);

// file: verif/mps_carrier.sv
// partner: carrier power circuitry, reset switch and power button
`timescale 1ns/1ps
module mps_carrier (
  input wire logic clk_sys,
  input wire logic power_ok,
  input wire logic press,
  input wire logic reset_pull,
  input wire logic carrier_standby_n,
  output logic input_power_fault_n,
  output logic reset_request_n,
  output logic power_button_input_n,
  output logic carrier_rails_on
);
  logic [2:0] settle_q = 3'h0;
  logic rails_q = 1'h0;
  // fault pin held low until input has been stable three cycles
  always @(posedge clk_sys) begin
    settle_q <= power_ok ? {settle_q[1:0], 1'h1} : 3'h0;
    rails_q <= carrier_standby_n;
  end
  assign input_power_fault_n = settle_q[2];
  // rails not needed in standby follow the standby pin
  assign carrier_rails_on = rails_q;
  // open-drain pins with pull-ups
  assign reset_request_n = reset_pull ? 1'h0 : 1'h1;
  assign power_button_input_n = press ? 1'h0 : 1'h1;
endmodule : mps_carrier

// file: verif/mps_sequencer_tb.sv
// testbench: power-up, soft-off, reset request and power loss
`timescale 1ns/1ps
module mps_sequencer_tb;
  import mps_pkg::*;
  logic clk_sys, rst_b, power_ok, press, reset_pull;
  logic input_power_fault_n, reset_request_n, power_button_input_n;
  mps_outputs_t outs, last;
  wire logic [3:0] dut_out;
  wire logic [3:0] nb_out;
  wire logic rails_on;
  mps_outputs_t exp_q[$];
  int err_count = 0;
  int total_checks = 0;
  mps_sequencer #(.SUPPLY_CYCLES(2), .CARRIER_CYCLES(4)) mps_sequencer_i (.clk_sys,
    .rst_b, .input_power_fault_n, .reset_request_n, .power_button_input_n,
    .supply_enable(dut_out[3]), .carrier_supply_enable(dut_out[2]),
    .carrier_standby_n(dut_out[1]), .reset_out_n(dut_out[0]));
  assign outs = dut_out;
  // same sequencer with no button fitted: good input power alone must boot it
  mps_sequencer #(.BUTTON_PRESENT(1'h0), .SUPPLY_CYCLES(2), .CARRIER_CYCLES(4))
    mps_sequencer_nobtn_i (.clk_sys, .rst_b, .input_power_fault_n, .reset_request_n,
    .power_button_input_n(1'h1), .supply_enable(nb_out[3]),
    .carrier_supply_enable(nb_out[2]), .carrier_standby_n(nb_out[1]),
    .reset_out_n(nb_out[0]));
  mps_carrier mps_carrier_i (.clk_sys, .power_ok, .press, .reset_pull,
    .carrier_standby_n(dut_out[1]), .input_power_fault_n, .reset_request_n,
    .power_button_input_n, .carrier_rails_on(rails_on));
  initial begin
    clk_sys = 1'h0;
    forever #50 clk_sys = ~clk_sys;
  end
  task chk(input logic [3:0] seen, input logic [3:0] want);
    total_checks++;
    if (seen !== want) begin
      err_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, want);
    end
  endtask : chk
  task test_done();
    $display("checks=%0d errors=%0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : test_done
  task cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : cyc
  task push(input logic [3:0] e);
    exp_q.push_back(e);
  endtask : push
  task do_press();
    press <= 1'h1;
    cyc(8 + $urandom % 8);
    press <= 1'h0;
    cyc(20);
  endtask : do_press
  // watcher: every output change takes the oldest note
  always @(negedge clk_sys) begin
    if (rst_b === 1'h1 && outs !== last) begin
      last = outs;
      if (exp_q.size() == 0) chk(outs, 4'hF ^ outs);
      else chk(outs, exp_q.pop_front());
    end
  end
  initial begin
    repeat (5000) @(posedge clk_sys);
    err_count++;
    test_done();
  end
  initial begin
    rst_b = 1'h0;
    power_ok = 1'h0;
    press = 1'h0;
    reset_pull = 1'h0;
    last = 4'h0;
    void'($urandom(32'he05d585a));
    cyc(3);
    rst_b <= 1'h1;
    cyc(2);
    @(negedge clk_sys);
    chk(outs, 4'h0);
    chk(nb_out, 4'h0);
    cyc(1);
    do_press(); // button in off is ignored
    push(4'h8);
    power_ok <= 1'h1;
    cyc(30);
    @(negedge clk_sys);
    chk(nb_out, 4'hF);
    cyc(1);
    push(4'hE);
    push(4'hF);
    do_press();
    push(4'h8);
    do_press();
    @(negedge clk_sys);
    chk({3'h0, rails_on}, 4'h0);
    chk(nb_out, 4'hF);
    cyc(1);
    push(4'hE);
    push(4'hF);
    do_press();
    push(4'hE);
    reset_pull <= 1'h1;
    cyc(20 + $urandom % 10);
    @(negedge clk_sys);
    chk(nb_out, 4'hE);
    cyc(1);
    push(4'hF);
    reset_pull <= 1'h0;
    cyc(30);
    push(4'h0);
    power_ok <= 1'h0;
    cyc(30);
    @(negedge clk_sys);
    chk({3'h0, exp_q.size() != 0}, 4'h0);
    chk(nb_out, 4'h0);
    test_done();
  end
endmodule : mps_sequencer_tb
